// ==== rtl/hsm_pkg.sv ====
package hsm_pkg;

    localparam int SYS_CLK_HZ      = 200_000_000;
    localparam int TICK_DIV        = 256;
    localparam int TICK_HZ         = SYS_CLK_HZ / TICK_DIV;
    localparam int SLOT_US         = 1000;
    localparam int TIMEOUT_US      = 16;
    localparam int SLOT_TICKS      = (SLOT_US * (TICK_HZ / 1000)) / 1000;
    localparam int TIMEOUT_TICKS   = ((TIMEOUT_US * TICK_HZ) + 999_999) / 1_000_000;
    localparam int TIMEOUT_CYCLES  = TIMEOUT_TICKS * TICK_DIV;
    localparam int BIT_RATE_HZ     = 1_000_000;
    localparam int HALF_BIT_CYCLES = SYS_CLK_HZ / BIT_RATE_HZ / 2;
    localparam int CHAR_BITS       = 8;
    // Cycles spent in the ready wait before the synchronised ready level is trusted.
    localparam int RDY_SETTLE      = 3;

    localparam logic [7:0] CMD_STATUS = 8'h00;
    localparam logic [1:0] DIR_RX     = 2'b01;
    localparam logic [1:0] DIR_TX     = 2'b10;
    localparam logic [1:0] DIR_TXRX   = 2'b11;
    localparam logic [1:0] STAT_CAN_TX = 2'b01;
    localparam logic [1:0] STAT_CAN_RX = 2'b00;

    typedef enum logic [3:0] {
        HSM_IDLE      = 4'b0000,
        HSM_SELECT    = 4'b0001,
        HSM_WAIT_RDY  = 4'b0010,
        HSM_SHIFT     = 4'b0011,
        HSM_CHAR_END  = 4'b0100,
        HSM_DESELECT  = 4'b0101,
        HSM_SWITCH    = 4'b0110
    } hsm_state_t;

    typedef struct packed {
        logic [7:0] data;
    } hsm_word_t;

    typedef struct packed {
        hsm_state_t  st;
        logic [7:0]  div;
        logic        tick;
        logic [9:0]  slot_cnt;
        logic        slot_ev;
        logic [15:0] tmo_cnt;
        logic        data_slot;
        logic        target;
        logic [7:0]  cmd;
        logic [5:0]  remain;
        logic [5:0]  cap;
        logic [7:0]  sh_out;
        logic [7:0]  sh_in;
        logic [3:0]  bit_cnt;
        logic [7:0]  half_cnt;
        logic        byte_is_cmd;
        logic        sck;
        logic        sdo;
        logic        sel1_n;
        logic        sel2_n;
        logic        char_done;
        logic        rx_valid;
        logic [7:0]  rx_data;
        logic        timeout;
        logic [1:0]  rdy_sync;
        logic [1:0]  sdi_sync;
    } hsm_regs_t;

endpackage

// ==== rtl/hsm_fifo.sv ====
`timescale 1ns/1ps
module hsm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp;
    logic [AW:0]      rp;
    logic             full;
    logic             empty;

    assign full      = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty     = (wp == rp);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp[AW-1:0]];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid && !full) begin
                wp <= wp + 1'b1;
            end
            if (out_ready && !empty) begin
                rp <= rp + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (in_valid && !full) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==== rtl/hsm_master.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - After reset both selects are high and slave ready is only an input.
// - The slot timer counts a tick made by dividing the clock by 256; the timeout timer counts clock cycles.
// - The slot timer expires every 1 ms; slots start only then.
// - Waiting for ready times out after 16 us; timeout means slave absent.
// - Characters are 8 bits, MSB first, one per transfer.
// - Clock and data phase uses type 1 on both sides.
// - Serial clock runs at 1 Mbps.
// - A completion pulse marks the end of each character.
// - On a slot tick select the target slave, then wait for ready.
// - Ready low continues; timeout first deselects and switches slave.
// - First slot sends status command, reads status; failure switches, success deselects.
// - After status, wait next tick, reselect same slave, wait ready again.
// - Data slot moves DATA_COUNT characters; timeout deselects.
// - After data slot or abort, toggle target slave, restart next tick.
// - Every operation starts with one command byte from the master.
// - Status command is all zeros, asking the slave's capacity.
// - Command 01 receives the count in the low six bits.
// - Command 10 transmits the count in the low six bits.
// - Command 11 transmits and receives the count in the low six bits.
// - Data transfer only if reported capacity covers the requested count.
// - Default data command is combined transmit and receive.
// - Ready low means prepared; no serial clock before seeing it.
// - After the command byte, wait for ready low again before data.
module hsm_master
    import hsm_pkg::*;
#(
    parameter logic [1:0] DATA_DIR   = DIR_TXRX,
    parameter logic [5:0] DATA_COUNT = 6'd8,
    parameter int         FIFO_DEPTH = 8,
    parameter int         SLOT_LEN   = SLOT_TICKS
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic                 slave_ready_port,
    input  wire logic                 serial_data_in,
    output logic                      serial_clock_out,
    output logic                      serial_data_out,
    output logic                      slave1_select_n,
    output logic                      slave2_select_n,
    output logic                      char_done_event,
    output logic                      timeout_tick_event,
    output logic                      slot_tick_event,
    output logic                      target_slave,
    output logic [5:0]                slave_capacity,
    input  wire hsm_pkg::hsm_word_t   tx_word,
    input  wire logic                 tx_valid,
    output logic                      tx_ready,
    output hsm_pkg::hsm_word_t        rx_word,
    output logic                      rx_valid,
    input  wire logic                 rx_ready
);
    import hsm_pkg::*;

    localparam logic [7:0]  TICK_LAST = 8'(TICK_DIV - 1);
    localparam logic [9:0]  SLOT_LAST = 10'(SLOT_LEN - 1);
    localparam logic [15:0] TMO_LAST  = 16'(TIMEOUT_CYCLES - 1);
    localparam logic [7:0]  HALF_LAST = 8'(HALF_BIT_CYCLES - 1);

    hsm_regs_t r;
    hsm_regs_t next_r;
    logic       rdy_low;
    logic       need_tx;
    logic       need_rx;
    logic [7:0] fifo_tx_data;
    logic       fifo_tx_valid;
    logic       fifo_rx_ready;
    logic       take_tx;

    assign rdy_low = !r.rdy_sync[1];
    assign need_tx = r.cmd[7];
    assign need_rx = (r.cmd[7:6] == DIR_RX) || (r.cmd[7:6] == DIR_TXRX);

    hsm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_data   (tx_word.data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (fifo_tx_data),
        .out_valid (fifo_tx_valid),
        .out_ready (take_tx)
    );

    hsm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_data   (r.rx_data),
        .in_valid  (r.rx_valid),
        .in_ready  (fifo_rx_ready),
        .out_data  (rx_word.data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    // Load a fresh character: command byte, FIFO data, or a dummy 0xFF.
    function automatic logic [7:0] load_byte(input logic is_cmd, input logic [7:0] cmd,
                                             input logic txn, input logic [7:0] d);
        if (is_cmd) begin
            load_byte = cmd;
        end else if (txn) begin
            load_byte = d;
        end else begin
            load_byte = 8'hFF;
        end
    endfunction

    always_comb begin
        next_r           = r;
        take_tx          = 1'b0;
        next_r.rdy_sync  = {r.rdy_sync[0], slave_ready_port};
        next_r.sdi_sync  = {r.sdi_sync[0], serial_data_in};
        next_r.char_done = 1'b0;
        next_r.rx_valid  = 1'b0;
        next_r.timeout   = 1'b0;
        next_r.slot_ev   = 1'b0;
        next_r.tick      = 1'b0;
        next_r.div       = r.div + 8'd1;
        if (r.div == TICK_LAST) begin
            next_r.div  = 8'd0;
            next_r.tick = 1'b1;
        end
        if (r.tick) begin
            next_r.slot_cnt = r.slot_cnt + 10'd1;
            if (r.slot_cnt == SLOT_LAST) begin
                next_r.slot_cnt = 10'd0;
                next_r.slot_ev  = 1'b1;
            end
        end
        case (r.st)
            HSM_IDLE: begin
                if (r.slot_ev) begin
                    next_r.st = HSM_SELECT;
                end
            end
            HSM_SELECT: begin
                next_r.sel1_n      = r.target;
                next_r.sel2_n      = !r.target;
                next_r.cmd         = r.data_slot ? {DATA_DIR, DATA_COUNT} : CMD_STATUS;
                next_r.remain      = r.data_slot ? DATA_COUNT : 6'd0;
                next_r.byte_is_cmd = 1'b1;
                next_r.tmo_cnt     = 16'd0;
                next_r.st          = HSM_WAIT_RDY;
                if (r.data_slot && (r.cap < DATA_COUNT)) begin
                    next_r.sel1_n    = 1'b1;
                    next_r.sel2_n    = 1'b1;
                    next_r.data_slot = 1'b0;
                    next_r.st        = HSM_DESELECT;
                end
            end
            HSM_WAIT_RDY: begin
                next_r.tmo_cnt = r.tmo_cnt + 16'd1;
                // The synchroniser still shows the level from before the last character for a few cycles.
                if (rdy_low && (r.tmo_cnt >= 16'(RDY_SETTLE))) begin
                    next_r.sh_out   = load_byte(r.byte_is_cmd, r.cmd, need_tx && fifo_tx_valid, fifo_tx_data);
                    take_tx         = !r.byte_is_cmd && need_tx && fifo_tx_valid;
                    next_r.bit_cnt  = 4'd0;
                    next_r.half_cnt = 8'd0;
                    next_r.st       = HSM_SHIFT;
                end else if (r.tmo_cnt == TMO_LAST) begin
                    next_r.timeout   = 1'b1;
                    next_r.data_slot = 1'b0;
                    next_r.st        = HSM_DESELECT;
                end
            end
            HSM_SHIFT: begin
                next_r.half_cnt = r.half_cnt + 8'd1;
                if (r.half_cnt == HALF_LAST) begin
                    next_r.half_cnt = 8'd0;
                    next_r.sck      = !r.sck;
                    if (r.sck) begin
                        next_r.sdo = r.sh_out[7];
                    end else begin
                        next_r.sh_in   = {r.sh_in[6:0], r.sdi_sync[1]};
                        next_r.sh_out  = {r.sh_out[6:0], 1'b1};
                        next_r.bit_cnt = r.bit_cnt + 4'd1;
                        if (r.bit_cnt == 4'(CHAR_BITS - 1)) begin
                            next_r.st = HSM_CHAR_END;
                        end
                    end
                end
            end
            HSM_CHAR_END: begin
                next_r.char_done   = 1'b1;
                next_r.byte_is_cmd = 1'b0;
                next_r.tmo_cnt     = 16'd0;
                if (!r.data_slot) begin
                    if (!r.byte_is_cmd) begin
                        next_r.cap       = r.sh_in[5:0];
                        next_r.data_slot = 1'b1;
                        next_r.st        = HSM_DESELECT;
                    end else begin
                        next_r.st = HSM_WAIT_RDY;
                    end
                end else begin
                    if (!r.byte_is_cmd) begin
                        next_r.remain   = r.remain - 6'd1;
                        next_r.rx_valid = need_rx && fifo_rx_ready;
                        next_r.rx_data  = r.sh_in;
                    end
                    next_r.st = HSM_WAIT_RDY;
                    if (!r.byte_is_cmd && (r.remain == 6'd1)) begin
                        next_r.data_slot = 1'b0;
                        next_r.st        = HSM_DESELECT;
                    end
                    if (r.byte_is_cmd && (r.remain == 6'd0)) begin
                        next_r.data_slot = 1'b0;
                        next_r.st        = HSM_DESELECT;
                    end
                end
            end
            HSM_DESELECT: begin
                next_r.sel1_n = 1'b1;
                next_r.sel2_n = 1'b1;
                next_r.sck    = 1'b1;
                next_r.st     = r.data_slot ? HSM_IDLE : HSM_SWITCH;
            end
            HSM_SWITCH: begin
                next_r.target = !r.target;
                next_r.st     = HSM_IDLE;
            end
            default: begin
                next_r.st = HSM_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r        <= '0;
            r.st     <= HSM_IDLE;
            r.sel1_n <= 1'b1;
            r.sel2_n <= 1'b1;
            r.sck    <= 1'b1;
            r.sdo    <= 1'b1;
            r.rdy_sync <= 2'b11;
        end else begin
            r <= next_r;
        end
    end

    assign serial_clock_out   = r.sck;
    assign serial_data_out    = r.sdo;
    assign slave1_select_n    = r.sel1_n;
    assign slave2_select_n    = r.sel2_n;
    assign char_done_event    = r.char_done;
    assign timeout_tick_event = r.timeout;
    assign slot_tick_event    = r.slot_ev;
    assign target_slave       = r.target;
    assign slave_capacity     = r.cap;

    never_both_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (r.sel1_n || r.sel2_n)) else $error("both slaves selected");
    no_clk_unsel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (r.sel1_n && r.sel2_n) |-> r.sck) else $error("clock active while deselected");
    slot_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (r.st == HSM_IDLE && next_r.st == HSM_SELECT) |-> r.slot_ev) else $error("slot began off tick");
    tick_period_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        r.tick |=> !r.tick [*8]) else $error("tick too frequent");
    timeout_len_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        r.timeout |-> $past(r.tmo_cnt) == TMO_LAST) else $error("timeout length wrong");
    timeout_desel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        r.timeout |=> ##1 (r.sel1_n && r.sel2_n)) else $error("no deselect after timeout");
    char_eight_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        r.char_done |-> $past(r.bit_cnt, 2) == 4'd7) else $error("char not eight bits");
    switch_after_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (r.st == HSM_SWITCH) |=> (r.target != $past(r.target))) else $error("target not toggled");
    sck_half_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (r.st == HSM_SHIFT && $fell(r.sck)) |=> !r.sck [*8]) else $error("clock half period short");
    cap_guard_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (r.st == HSM_SELECT && r.data_slot && (r.cap < DATA_COUNT)) |=> (r.sel1_n && r.sel2_n))
        else $error("select despite low capacity");

    cov_timeout_c: cover property (@(posedge core_clk) disable iff (!rst_b) r.timeout);
    cov_status_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        r.char_done && !r.data_slot);
    cov_data_c: cover property (@(posedge core_clk) disable iff (!rst_b) r.rx_valid);
    cov_switch_c: cover property (@(posedge core_clk) disable iff (!rst_b) r.st == HSM_SWITCH);
endmodule

// ==== tb/hsm_slave_model.sv ====
`timescale 1ns/1ps
module hsm_slave_model (
    input  wire logic        core_clk,
    input  wire logic        select_n,
    input  wire logic        sck,
    input  wire logic        mosi,
    input  wire logic [7:0]  status_reply,
    input  wire logic [15:0] ready_delay,
    output logic             miso,
    output logic             ready_n
);
    logic [7:0]  sh_in   = 8'h00;
    logic [7:0]  sh_out  = 8'h00;
    logic [7:0]  cmd     = 8'h00;
    logic [15:0] dly     = 16'h0000;
    int          bit_n   = 0;
    int          byte_n  = 0;
    int          done_n  = 0;
    int          seen_n  = 0;
    int          early_n = 0;
    logic [7:0]  got_q[$];

    initial begin
        miso = 1'b0;
        ready_n = 1'b1;
    end

    // Ready drops after the chosen delay and rises again after every character.
    always @(posedge core_clk) begin
        if (select_n || seen_n != done_n) begin
            ready_n <= 1'b1;
            dly <= 16'h0000;
            seen_n <= done_n;
        end else if (dly < ready_delay) begin
            dly <= dly + 16'h0001;
        end else begin
            ready_n <= 1'b0;
        end
    end

    always @(negedge select_n) begin
        bit_n = 0;
        byte_n = 0;
    end

    // A released data line must not keep showing its last bit.
    always @(posedge select_n) begin
        miso <= ~miso;
    end

    always @(negedge sck) begin
        if (select_n || ready_n) early_n++;
        if (bit_n == 0) begin
            if (byte_n == 0) sh_out = 8'h5A;
            else if (cmd == 8'h00) sh_out = status_reply;
            else sh_out = 8'h30 + 8'(byte_n - 1);
        end
        miso <= sh_out[7];
        sh_out = {sh_out[6:0], 1'b0};
    end

    always @(posedge sck) begin
        if (!select_n) begin
            sh_in = {sh_in[6:0], mosi};
            bit_n++;
            if (bit_n == 8) begin
                got_q.push_back(sh_in);
                if (byte_n == 0) cmd = sh_in;
                byte_n++;
                bit_n = 0;
                done_n++;
            end
        end
    end
endmodule

// ==== tb/tb_hsm_master.sv ====
`timescale 1ns/1ps
module tb_hsm_master;
    import hsm_pkg::*;
    localparam int PER = 5;
    localparam int SLOT = 0;
    localparam int SEL1 = 1;
    localparam int SEL2 = 2;
    localparam int TMO  = 3;
    localparam int TGT  = 4;
    localparam int SLOT_LEN  = 40;
    localparam int SLOT_WAIT = SLOT_LEN * TICK_DIV + 1000;
    logic        core_clk;
    logic        rst_b;
    logic        ready_n;
    logic        miso;
    logic        sck;
    logic        mosi;
    logic        sel1_n;
    logic        sel2_n;
    logic        char_done;
    logic        tmo_ev;
    logic        slot_ev;
    logic        target;
    logic [5:0]  cap;
    hsm_word_t   tx_word;
    logic        tx_valid;
    logic        tx_ready;
    hsm_word_t   rx_word;
    logic        rx_valid;
    logic        rx_ready;
    logic [7:0]  reply;
    logic [15:0] rdy_dly;
    int          err_count = 0;
    int          n_checks  = 0;
    int          n_chars   = 0;
    time         t_rise    = 0;
    time         t_prev    = 0;
    time         t_tick    = 0;

    hsm_master #(.DATA_DIR(DIR_TXRX), .DATA_COUNT(6'd8), .FIFO_DEPTH(8), .SLOT_LEN(SLOT_LEN)) DUT (
        .core_clk(core_clk), .rst_b(rst_b), .slave_ready_port(ready_n), .serial_data_in(miso),
        .serial_clock_out(sck), .serial_data_out(mosi), .slave1_select_n(sel1_n), .slave2_select_n(sel2_n),
        .char_done_event(char_done), .timeout_tick_event(tmo_ev), .slot_tick_event(slot_ev),
        .target_slave(target), .slave_capacity(cap), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));

    hsm_slave_model slave (
        .core_clk(core_clk), .select_n(sel1_n), .sck(sck), .mosi(mosi), .status_reply(reply),
        .ready_delay(rdy_dly), .miso(miso), .ready_n(ready_n));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) if (char_done === 1'b1) n_chars++;
    always @(posedge sck) begin
        t_prev = t_rise;
        t_rise = $time;
    end

    task automatic cyc();
        @(posedge core_clk);
        #1;
    endtask

    task automatic fail(string msg);
        $display("Error at %0t: %s", $time, msg);
        err_count++;
    endtask

    task automatic check_bit(logic act, logic exp, string what);
        n_checks++;
        if (act !== exp) fail($sformatf("%s got %b want %b", what, act, exp));
    endtask

    task automatic check_byte(logic [7:0] act, logic [7:0] exp, string what);
        n_checks++;
        if (act !== exp) fail($sformatf("%s got %h want %h", what, act, exp));
    endtask

    task automatic check_range(int act, int lo, int hi, string what);
        n_checks++;
        if (act < lo || act > hi) fail($sformatf("%s got %0d want %0d..%0d", what, act, lo, hi));
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic pick(int s);
        case (s)
            SLOT: return slot_ev;
            SEL1: return sel1_n;
            SEL2: return sel2_n;
            TMO: return tmo_ev;
            default: return target;
        endcase
    endfunction

    task automatic wait_for(int s, logic lvl, int lim, output int n);
        n = 0;
        while (pick(s) !== lvl && n < lim) begin
            cyc();
            n++;
        end
        if (n >= lim) begin
            fail("wait limit reached");
            test_done();
        end
    endtask

    task automatic test_reset();
        check_bit(sel1_n, 1'b1, "select 1 idle");
        check_bit(sel2_n, 1'b1, "select 2 idle");
        check_bit(sck, 1'b1, "clock idle");
        check_bit(target, 1'b0, "target");
        check_byte({2'b00, cap}, 8'h00, "capacity");
        $display("test_reset done");
    endtask

    task automatic test_fifo();
        int i;
        for (i = 0; i < 9; i++) begin
            tx_word.data = 8'hA0 + 8'(i);
            tx_valid = 1'b1;
            check_bit(tx_ready, (i < 8) ? 1'b1 : 1'b0, "tx space");
            cyc();
        end
        tx_valid = 1'b0;
        $display("test_fifo done");
    endtask

    task automatic test_status();
        int n;
        wait_for(SLOT, 1'b1, SLOT_WAIT, n);
        t_tick = $time;
        wait_for(SEL1, 1'b0, 10, n);
        check_range(n, 2, 2, "select delay");
        check_bit(sel2_n, 1'b1, "other select");
        wait_for(SEL1, 1'b1, 20000, n);
        check_byte(slave.got_q[0], CMD_STATUS, "status command");
        check_range(slave.got_q.size(), 2, 2, "status bytes");
        check_range(n_chars, 2, 2, "char events");
        check_byte({2'b00, cap}, 8'h08, "capacity");
        check_range(int'(t_rise - t_prev), 2 * HALF_BIT_CYCLES * PER, 2 * HALF_BIT_CYCLES * PER, "bit time");
        check_bit(target, 1'b0, "target kept");
        $display("test_status done");
    endtask

    task automatic test_data();
        int n;
        int k;
        rdy_dly = 16'd1000;
        slave.got_q.delete();
        n_chars = 0;
        wait_for(SLOT, 1'b1, SLOT_WAIT, n);
        check_range(int'(($time - t_tick) / PER), SLOT_LEN * TICK_DIV, SLOT_LEN * TICK_DIV, "slot");
        wait_for(SEL1, 1'b0, 10, n);
        check_range(n, 2, 2, "reselect delay");
        wait_for(SEL1, 1'b1, 40000, n);
        check_byte(slave.got_q[0], {DIR_TXRX, 6'd8}, "data command");
        check_range(slave.got_q.size(), 9, 9, "data bytes");
        for (k = 1; k < 9; k++) check_byte(slave.got_q[k], 8'hA0 + 8'(k - 1), "sent byte");
        check_range(n_chars, 9, 9, "char events");
        wait_for(TGT, 1'b1, 10, n);
        rx_ready = 1'b1;
        for (k = 0; k < 8; k++) begin
            check_bit(rx_valid, 1'b1, "rx word present");
            check_byte(rx_word.data, 8'h30 + 8'(k), "received byte");
            cyc();
        end
        rx_ready = 1'b0;
        check_bit(rx_valid, 1'b0, "rx empty");
        $display("test_data done");
    endtask

    task automatic test_timeout();
        int n;
        wait_for(SLOT, 1'b1, SLOT_WAIT, n);
        wait_for(SEL2, 1'b0, 10, n);
        check_range(n, 2, 2, "select 2 delay");
        check_bit(sel1_n, 1'b1, "select 1 idle");
        wait_for(TMO, 1'b1, 4000, n);
        check_range(n, TIMEOUT_CYCLES - TICK_DIV, TIMEOUT_CYCLES + TICK_DIV, "timeout");
        wait_for(SEL2, 1'b1, 10, n);
        wait_for(TGT, 1'b0, 10, n);
        check_bit(sck, 1'b1, "no clock");
        check_range(slave.early_n, 0, 0, "clock before ready");
        $display("test_timeout done");
    endtask

    task automatic test_refuse();
        int n;
        reply = 8'h44;
        wait_for(SLOT, 1'b1, SLOT_WAIT, n);
        wait_for(SEL1, 1'b0, 10, n);
        wait_for(SEL1, 1'b1, 20000, n);
        check_byte({2'b00, cap}, 8'h04, "small capacity");
        wait_for(SLOT, 1'b1, SLOT_WAIT, n);
        repeat (6) begin
            check_bit(sel1_n, 1'b1, "refused select");
            cyc();
        end
        check_bit(target, 1'b1, "switch after refusal");
        $display("test_refuse done");
    endtask

    initial begin
        rst_b = 1'b0;
        tx_word = '0;
        tx_valid = 1'b0;
        rx_ready = 1'b0;
        reply = 8'h48;
        rdy_dly = 16'd20;
        repeat (4) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        test_reset();
        test_fifo();
        test_status();
        test_data();
        test_timeout();
        test_refuse();
        test_done();
    end
endmodule
